// ---- rtl/uart_fifo_bus_slave.sv ----
// Serial port with two character queues behind a peripheral bus slave
// Functional notes
// - Separate 16-character transmit and receive queues
// - Transmitter and receiver run independently, concurrently
// - Data bits per character: parameter 5..8
// - Parameter selects parity present, default on
// - Parameter selects odd or even parity
// - Bit rate from rate and clock parameters
// - Answer only inside base..high address window
// - Word registers, bit 0 most significant
// - Offsets 0 rx, 4 tx, 8 status, 12 control
// - Bit 24 parity fault; character still queued
// - Bit 25 framing fault; character dropped
// - Bit 26 overrun; new character dropped
// - Status read clears three fault flags
// - Bit 27 shows interrupt enable state
// - Bits 28-31 show queue full/empty/valid
// - Control bit 27 sets interrupt enable
// - Control bits 30/31 empty rx/tx queues
// - Interrupt held while receive queue nonempty
// - One-cycle interrupt when tx queue drains
// - 32-bit data and address, byte enables
`timescale 1ns/1ps
`include "uart_fifo_params.svh"

// Sixteen-entry character queue with synchronous clear
module char_queue (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  output logic            empty,
  output logic            full
);
  logic [7:0] mem [`QUEUE_DEPTH];  // Storage, no reset needed
  logic [3:0] wr_reg, wr_next;     // Write pointer
  logic [3:0] rd_reg, rd_next;     // Read pointer
  logic [4:0] cnt_reg, cnt_next;   // Fill level 0..16
  logic       do_push;
  logic       do_pop;

  assign empty   = (cnt_reg == 5'h00);
  assign full    = (cnt_reg == 5'h10);
  assign dout    = mem[rd_reg];
  // Push on full and pop on empty are ignored
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  // Pointer and level update; clear wins over both
  always_comb
  begin
    wr_next  = wr_reg + {3'h0, do_push};
    rd_next  = rd_reg + {3'h0, do_pop};
    cnt_next = cnt_reg + {4'h0, do_push} - {4'h0, do_pop};
    if (clr)
    begin
      wr_next  = 4'h0;
      rd_next  = 4'h0;
      cnt_next = 5'h00;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_reg  <= 4'h0;
      rd_reg  <= 4'h0;
      cnt_reg <= 5'h00;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage write; a clear in the same cycle makes it harmless
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_reg] <= din;
  end
endmodule : char_queue

// Top level: bus slave, queues, transmitter and receiver
module uart_fifo_bus_slave #(
  parameter int          bit_rate_param     = 19200,
  parameter int          bus_clock_hz_param = 125000000,
  parameter int          data_bits_param    = 8,          // 5..8
  parameter int          use_parity_param   = 1,
  parameter int          odd_parity_param   = 1,
  parameter logic [31:0] decode_low_param   = 32'h0000_0000,
  parameter logic [31:0] decode_high_param  = 32'h0000_000F
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [0:31] bus_addr,
  input  wire logic [0:3]  bus_be,
  input  wire logic [0:31] bus_wdata,
  input  wire logic        bus_rnw,
  input  wire logic        bus_select,
  input  wire logic        bus_seq_addr,
  output logic      [0:31] bus_rdata,
  output logic             transfer_acknowledge,
  output logic             error_acknowledge,
  output logic             retry,
  output logic             timeout_suppress,
  output logic             interrupt,
  input  wire logic        rx,
  output logic             tx
);
  import uart_fifo_pkg::*;

  localparam int bus_data_width_param = 32;
  localparam int bus_addr_width_param = 32;
  // Divider rounds down, so bits run at most one clock short each tick
  localparam int TICK_DIV = bus_clock_hz_param / (bit_rate_param * `OVERSAMPLE);
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);
  localparam logic [7:0]  DATA_MASK = 8'((32'h1 << data_bits_param) - 32'h1);
  localparam logic [2:0]  LAST_BIT  = 3'(data_bits_param - 1);
  localparam logic        USE_PAR   = (use_parity_param != 0);
  localparam logic        ODD_PAR   = (odd_parity_param != 0);

  // Oversample tick shared by both directions
  logic [15:0] os_reg, os_next;
  logic        tick;
  // Receive line synchroniser and filtered level
  logic [2:0]  rx_sync_reg, rx_sync_next;
  logic        rx_level_reg, rx_level_next;
  // Bus slave state
  logic        ack_reg, ack_next;
  logic [0:31] rdata_reg, rdata_next;
  logic        hit, req;
  logic [3:0]  offset;
  logic        rx_pop, stat_rd, tx_push, ctrl_wr;
  // Control and sticky faults
  logic        irq_en_reg, irq_en_next;
  logic        par_flag_reg, par_flag_next;
  logic        frame_flag_reg, frame_flag_next;
  logic        ovr_flag_reg, ovr_flag_next;
  logic        tx_empty_d_reg;
  // Queue ports
  logic [7:0]  txq_dout, rxq_dout;
  logic        txq_empty, txq_full, rxq_empty, rxq_full;
  logic        tx_pop, rx_push, clr_rx, clr_tx;
  // Transmitter
  line_state_t tx_state_reg, tx_state_next;
  logic [3:0]  tx_sub_reg, tx_sub_next;
  logic [2:0]  tx_bit_reg, tx_bit_next;
  logic [7:0]  tx_shift_reg, tx_shift_next;
  logic        tx_par_reg, tx_par_next;
  logic        tx_line_reg, tx_line_next;
  // Receiver
  line_state_t rx_state_reg, rx_state_next;
  logic [3:0]  rx_sub_reg, rx_sub_next;
  logic [2:0]  rx_bit_reg, rx_bit_next;
  logic [7:0]  rx_shift_reg, rx_shift_next;
  logic        rx_par_reg, rx_par_next;
  logic        rx_armed_reg, rx_armed_next;  // Line seen high since the last frame
  logic        rx_done;
  logic [7:0]  rx_char;
  logic        par_bad, frame_bad;

  // Both directions own a queue and run side by side
  char_queue u_txq (
    .clk(clk), .rst(rst), .clr(clr_tx), .push(tx_push), .pop(tx_pop),
    .din(bus_wdata[24:31] & DATA_MASK), .dout(txq_dout), .empty(txq_empty), .full(txq_full)
  );
  char_queue u_rxq (
    .clk(clk), .rst(rst), .clr(clr_rx), .push(rx_push), .pop(rx_pop),
    .din(rx_char), .dout(rxq_dout), .empty(rxq_empty), .full(rxq_full)
  );

  // Tick divider and input synchroniser
  always_comb
  begin
    tick          = (os_reg == TICK_LAST);
    os_next       = tick ? 16'h0000 : os_reg + 16'h0001;
    rx_sync_next  = {rx_sync_reg[1:0], rx};
    // Level changes only once the second and third stages agree
    rx_level_next = (rx_sync_reg[1] == rx_sync_reg[2]) ? rx_sync_reg[2] : rx_level_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      os_reg       <= 16'h0000;
      rx_sync_reg  <= 3'h7;
      rx_level_reg <= 1'b1;
    end
    else
    begin
      os_reg       <= os_next;
      rx_sync_reg  <= rx_sync_next;
      rx_level_reg <= rx_level_next;
    end
  end

  // Address window and decode; words only, so low two bits are ignored
  assign hit     = bus_select && (bus_addr >= decode_low_param) && (bus_addr <= decode_high_param);
  assign req     = hit && !ack_reg;
  assign offset  = {bus_addr[28:29], 2'b00};
  assign rx_pop  = req && bus_rnw && (offset == `OFF_RX_PORT);
  assign stat_rd = req && bus_rnw && (offset == `OFF_STATUS);
  assign tx_push = req && !bus_rnw && (offset == `OFF_TX_PORT) && bus_be[3];
  assign ctrl_wr = req && !bus_rnw && (offset == `OFF_CTRL) && bus_be[3];
  assign clr_rx  = ctrl_wr && bus_wdata[`CT_CLR_RX];
  assign clr_tx  = ctrl_wr && bus_wdata[`CT_CLR_TX];

  // Bus answer and control; faults set wins over a status-read clear
  always_comb
  begin
    ack_next   = req;
    rdata_next = 32'h0000_0000;
    if (rx_pop)
      rdata_next[24:31] = rxq_dout;
    else if (stat_rd)
    begin
      rdata_next[`ST_PAR_FAULT]   = par_flag_reg;
      rdata_next[`ST_FRAME_FAULT] = frame_flag_reg;
      rdata_next[`ST_OVR_FAULT]   = ovr_flag_reg;
      rdata_next[`ST_IRQ_ON]      = irq_en_reg;
      rdata_next[`ST_TX_FULL]     = txq_full;
      rdata_next[`ST_TX_EMPTY]    = txq_empty;
      rdata_next[`ST_RX_FULL]     = rxq_full;
      rdata_next[`ST_RX_VALID]    = !rxq_empty;
    end
    irq_en_next     = ctrl_wr ? bus_wdata[`CT_IRQ_ENABLE] : irq_en_reg;
    par_flag_next   = par_bad || (par_flag_reg && !stat_rd);
    frame_flag_next = frame_bad || (frame_flag_reg && !stat_rd);
    ovr_flag_next   = (rx_done && !frame_bad && rxq_full) || (ovr_flag_reg && !stat_rd);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_reg        <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      irq_en_reg     <= `IRQ_EN_RESET;
      par_flag_reg   <= `FLAG_RESET;
      frame_flag_reg <= `FLAG_RESET;
      ovr_flag_reg   <= `FLAG_RESET;
      tx_empty_d_reg <= 1'b1;
    end
    else
    begin
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
      irq_en_reg     <= irq_en_next;
      par_flag_reg   <= par_flag_next;
      frame_flag_reg <= frame_flag_next;
      ovr_flag_reg   <= ovr_flag_next;
      tx_empty_d_reg <= txq_empty;
    end
  end

  assign bus_rdata            = rdata_reg;
  assign transfer_acknowledge = ack_reg;
  assign error_acknowledge    = 1'b0;
  assign retry                = 1'b0;
  assign timeout_suppress     = 1'b0;
  // Level for waiting characters, one-cycle pulse when tx drains
  assign interrupt = irq_en_reg && (!rxq_empty || (txq_empty && !tx_empty_d_reg));
  assign tx        = tx_line_reg;

  // Transmitter: each bit lasts sixteen ticks
  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_sub_next   = tick ? tx_sub_reg + 4'h1 : tx_sub_reg;
    tx_bit_next   = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    tx_par_next   = tx_par_reg;
    tx_line_next  = tx_line_reg;
    tx_pop        = 1'b0;
    case (tx_state_reg)
      LINE_IDLE:
      begin
        tx_sub_next  = 4'h0;
        tx_line_next = 1'b1;
        if (!txq_empty)
        begin
          tx_pop        = 1'b1;
          tx_shift_next = txq_dout;
          tx_par_next   = (^(txq_dout & DATA_MASK)) ^ ODD_PAR;
          tx_line_next  = 1'b0;
          tx_state_next = LINE_START;
        end
      end
      LINE_START:
        if (tick && tx_sub_reg == `LAST_TICK)
        begin
          tx_line_next  = tx_shift_reg[0];
          tx_shift_next = {1'b0, tx_shift_reg[7:1]};
          tx_bit_next   = 3'h0;
          tx_state_next = LINE_DATA;
        end
      LINE_DATA:
        if (tick && tx_sub_reg == `LAST_TICK)
        begin
          if (tx_bit_reg == LAST_BIT)
          begin
            tx_line_next  = USE_PAR ? tx_par_reg : 1'b1;
            tx_state_next = USE_PAR ? LINE_PARITY : LINE_STOP;
          end
          else
          begin
            tx_line_next  = tx_shift_reg[0];
            tx_shift_next = {1'b0, tx_shift_reg[7:1]};
            tx_bit_next   = tx_bit_reg + 3'h1;
          end
        end
      LINE_PARITY:
        if (tick && tx_sub_reg == `LAST_TICK)
        begin
          tx_line_next  = 1'b1;
          tx_state_next = LINE_STOP;
        end
      default:
        if (tick && tx_sub_reg == `LAST_TICK)
          tx_state_next = LINE_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_reg <= LINE_IDLE;
      tx_sub_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg   <= 1'b0;
      tx_line_reg  <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_sub_reg   <= tx_sub_next;
      tx_bit_reg   <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      tx_par_reg   <= tx_par_next;
      tx_line_reg  <= tx_line_next;
    end
  end

  // Receiver: confirm start at mid-bit, then sample every sixteen ticks
  assign rx_char   = 8'(rx_shift_reg >> (8 - data_bits_param));
  assign rx_done   = (rx_state_reg == LINE_STOP) && tick && (rx_sub_reg == `LAST_TICK);
  assign frame_bad = rx_done && !rx_level_reg;
  assign par_bad   = rx_done && rx_level_reg && USE_PAR
                     && (rx_par_reg != ((^rx_char) ^ ODD_PAR));
  // Parity faults still enter; full queue drops the new one
  assign rx_push   = rx_done && rx_level_reg && !rxq_full;

  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_sub_next   = tick ? rx_sub_reg + 4'h1 : rx_sub_reg;
    rx_bit_next   = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_par_next   = rx_par_reg;
    rx_armed_next = rx_armed_reg;
    case (rx_state_reg)
      LINE_IDLE:
      begin
        rx_sub_next = 4'h0;
        // A start needs a high line first, so a low stop cannot restart a frame
        if (rx_level_reg)
          rx_armed_next = 1'b1;
        else if (rx_armed_reg)
        begin
          rx_armed_next = 1'b0;
          rx_state_next = LINE_START;
        end
      end
      LINE_START:
        if (tick && rx_sub_reg == `MID_TICK)
        begin
          // A glitch shorter than half a bit is not a start
          rx_sub_next   = 4'h0;
          rx_bit_next   = 3'h0;
          rx_state_next = rx_level_reg ? LINE_IDLE : LINE_DATA;
        end
      LINE_DATA:
        if (tick && rx_sub_reg == `LAST_TICK)
        begin
          rx_shift_next = {rx_level_reg, rx_shift_reg[7:1]};
          rx_bit_next   = rx_bit_reg + 3'h1;
          if (rx_bit_reg == LAST_BIT)
            rx_state_next = USE_PAR ? LINE_PARITY : LINE_STOP;
        end
      LINE_PARITY:
        if (tick && rx_sub_reg == `LAST_TICK)
        begin
          rx_par_next   = rx_level_reg;
          rx_state_next = LINE_STOP;
        end
      default:
        if (rx_done)
          rx_state_next = LINE_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state_reg <= LINE_IDLE;
      rx_sub_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg   <= 1'b0;
      rx_armed_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_sub_reg   <= rx_sub_next;
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_par_reg   <= rx_par_next;
      rx_armed_reg <= rx_armed_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_new_req;
    hit && !ack_reg;
  endsequence
  sequence s_one_ack;
    transfer_acknowledge ##1 !transfer_acknowledge;
  endsequence
  a_ack_single: assert property (s_new_req |=> s_one_ack)
    else $error("acknowledge not a single cycle");
  a_acks_quiet: assert property (!error_acknowledge && !retry && !timeout_suppress)
    else $error("error or retry answer raised");
  a_ack_in_window: assert property (transfer_acknowledge |-> $past(hit))
    else $error("acknowledge outside the window");
  a_rx_irq_level: assert property (irq_en_reg && !rxq_empty |-> interrupt)
    else $error("interrupt low with data waiting");
  a_tx_irq_pulse: assert property (irq_en_reg && rxq_empty && txq_empty
    && !$past(txq_empty) |-> interrupt ##1 (!interrupt || !rxq_empty))
    else $error("drain interrupt not one cycle");
  a_flag_cleared: assert property (stat_rd && !par_bad |=> !par_flag_reg)
    else $error("parity flag survived status read");
  a_frame_drop: assert property (frame_bad |-> !rx_push ##1 frame_flag_reg)
    else $error("framing fault not flagged or char queued");
  a_ovr_drop: assert property (rx_done && rx_level_reg && rxq_full
    && !rx_pop && !clr_rx |=> ovr_flag_reg && rxq_full)
    else $error("overrun not flagged");
  a_rdata_idle: assert property (!transfer_acknowledge |-> bus_rdata == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  a_tx_start_bit: assert property (tx_state_reg == LINE_IDLE && !txq_empty
    |=> !tx ##1 !tx)
    else $error("no start bit after queue load");
endmodule : uart_fifo_bus_slave

// ---- rtl/uart_fifo_params.svh ----
// Register offsets, bit positions, reset values and timing counts of the serial port
`ifndef UART_FIFO_PARAMS_SVH
`define UART_FIFO_PARAMS_SVH

// Register offsets (low four address bits)
`define OFF_RX_PORT    4'h0
`define OFF_TX_PORT    4'h4
`define OFF_STATUS     4'h8
`define OFF_CTRL       4'hC

// Status bit labels, bit 0 most significant
`define ST_PAR_FAULT   24
`define ST_FRAME_FAULT 25
`define ST_OVR_FAULT   26
`define ST_IRQ_ON      27
`define ST_TX_FULL     28
`define ST_TX_EMPTY    29
`define ST_RX_FULL     30
`define ST_RX_VALID    31

// Control bit labels
`define CT_IRQ_ENABLE  27
`define CT_CLR_RX      30
`define CT_CLR_TX      31

// Reset values
`define IRQ_EN_RESET   1'b0
`define FLAG_RESET     1'b0

// Queue geometry and sampling
`define QUEUE_DEPTH    16
`define OVERSAMPLE     16
`define MID_TICK       4'h7
`define LAST_TICK      4'hF

`endif

// ---- rtl/uart_fifo_pkg.sv ----
// Types shared by the serial port logic
package uart_fifo_pkg;
  // Gray-coded along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    LINE_IDLE   = 3'h0,
    LINE_START  = 3'h1,
    LINE_DATA   = 3'h3,
    LINE_PARITY = 3'h2,
    LINE_STOP   = 3'h6
  } line_state_t;
endpackage : uart_fifo_pkg

// ---- tb/serial_peer.sv ----
// Behavioural far-end serial device: frame sender and frame decoder
`timescale 1ns/1ps
module serial_peer #(
  parameter int bit_clks  = 160,  // Clocks per serial bit
  parameter int odd_par   = 1     // 1 odd parity, 0 even
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_char;  // Last decoded character
  logic       got_good;  // Start, parity and stop of last frame correct
  int         n_got;     // Frames decoded so far

  // Line rests high while no frame is sent
  initial
  begin
    line_out = 1'b1;
    n_got = 0;
  end

  // Hold one bit level for a full bit time
  task automatic put(input logic b);
    @(posedge clk);
    line_out <= b;
    repeat (bit_clks - 1) @(posedge clk);
  endtask : put

  // One 8-bit frame; the flags corrupt parity or stop on purpose
  task automatic send(input logic [7:0] ch, input logic bad_par, input logic bad_stop);
    int i;
    put(1'b0);                                     // Start bit
    for (i = 0; i < 8; i++)
      put(ch[i]);                                  // LSB first
    put((^ch) ^ odd_par[0] ^ bad_par);             // Parity bit
    put(~bad_stop);                                // Stop bit
    put(1'b1);                                     // Idle gap so the char lands
  endtask : send

  // Decoder samples each bit at its centre
  always
  begin : decode
    logic [7:0] c;
    logic       s;
    logic       p;
    int         i;
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk);
    s = line_in;
    for (i = 0; i < 8; i++)
    begin
      repeat (bit_clks) @(posedge clk);
      c[i] = line_in;
    end
    repeat (bit_clks) @(posedge clk);
    p = line_in;
    repeat (bit_clks) @(posedge clk);
    got_good = (s == 1'b0) && (p == ((^c) ^ odd_par[0])) && (line_in == 1'b1);
    got_char = c;
    n_got++;
  end
endmodule : serial_peer

// ---- tb/testbench.sv ----
// Self-checking bench for the queued serial port bus slave
`timescale 1ns/1ps
`include "uart_fifo_params.svh"
module testbench;
  localparam int bit_clks = 160;  // 1.6 MHz over 10 kbit/s
  logic        clk;
  logic        rst;
  logic [0:31] bus_addr;
  logic [0:3]  bus_be;
  logic [0:31] bus_wdata;
  logic        bus_rnw;
  logic        bus_select;
  logic [0:31] bus_rdata;
  logic        transfer_acknowledge;
  logic        error_acknowledge;
  logic        retry;
  logic        timeout_suppress;
  logic        interrupt;
  logic        rx;
  logic        tx;
  int          errors;
  int          n_checks;
  int          irq_cnt;   // Interrupt-high cycles seen by the monitor
  logic [31:0] rd;

  uart_fifo_bus_slave #(.bit_rate_param(10000), .bus_clock_hz_param(1600000))
    uart_fifo_bus_slave_inst (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rnw(bus_rnw), .bus_select(bus_select), .bus_seq_addr(1'b0),
    .bus_rdata(bus_rdata), .transfer_acknowledge(transfer_acknowledge),
    .error_acknowledge(error_acknowledge), .retry(retry), .timeout_suppress(timeout_suppress),
    .interrupt(interrupt), .rx(rx), .tx(tx));

  serial_peer #(.bit_clks(bit_clks), .odd_par(1))
    serial_peer_inst (.clk(clk), .line_in(tx), .line_out(rx));

  // Clock and interrupt monitor; sampling mid-cycle avoids edge races
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk)
    if (interrupt === 1'b1)
      irq_cnt++;

  task automatic end_sim;
    $display("TB: checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One bus transfer; select held until the acknowledge edge
  task automatic bus(input logic [31:0] a, input logic rnw, input logic [31:0] wd,
                     input logic want);
    logic got;
    int   i;
    got = 1'b0;
    @(posedge clk);
    bus_addr <= a;
    bus_rnw <= rnw;
    bus_wdata <= wd;
    bus_select <= 1'b1;
    for (i = 0; i < 8 && !got; i++)
    begin
      @(negedge clk);
      if (transfer_acknowledge === 1'b1)
      begin
        got = 1'b1;
        rd = bus_rdata;
        check("side_answers", 32'h0, {29'h0, error_acknowledge, retry, timeout_suppress});
      end
    end
    @(posedge clk);
    bus_select <= 1'b0;
    @(negedge clk);
    check("ack_seen", {31'h0, want}, {31'h0, got});
    check("ack_width", 32'h0, {31'h0, transfer_acknowledge});
    if (want && !got)
      end_sim();
  endtask : bus

  task automatic rd_chk(input logic [3:0] off, input logic [31:0] exp, input string name);
    bus({28'h0, off}, 1'b1, 32'h0, 1'b1);
    check(name, exp, rd);
  endtask : rd_chk

  task automatic wr(input logic [3:0] off, input logic [31:0] d);
    bus({28'h0, off}, 1'b0, d, 1'b1);
  endtask : wr

  task automatic t_reset;
    check("tx_idle", 32'h1, {31'h0, tx});
    rd_chk(`OFF_STATUS, 32'h04, "status_reset");
    wr(`OFF_CTRL, 32'h10);
    rd_chk(`OFF_STATUS, 32'h14, "status_irq_on");
    // Low byte lane off: the character must not reach the transmitter
    bus_be <= 4'hE;
    wr(`OFF_TX_PORT, 32'h55);
    bus_be <= 4'hF;
    check("be_ignored", 32'h1, {31'h0, tx});
    bus(32'h10, 1'b1, 32'h0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Transmit one character, drain pulse lasts one cycle
  task automatic t_tx;
    int n0;
    int i;
    n0 = serial_peer_inst.n_got;
    irq_cnt = 0;
    wr(`OFF_TX_PORT, 32'hFFFF_FF5A);
    for (i = 0; i < 3 * 11 * bit_clks && serial_peer_inst.n_got == n0; i++)
      @(posedge clk);
    if (serial_peer_inst.n_got == n0)
    begin
      check("frame_timeout", 32'h1, 32'h0);
      end_sim();
    end
    check("tx_char", 32'h5A, {24'h0, serial_peer_inst.got_char});
    check("tx_frame", 32'h1, {31'h0, serial_peer_inst.got_good});
    check("drain_pulse", 32'h1, irq_cnt);
    $display("test tx done");
  endtask : t_tx

  // Good, bad-parity and bad-stop frames into the receiver
  task automatic t_rx;
    serial_peer_inst.send(8'h3C, 1'b0, 1'b0);
    rd_chk(`OFF_STATUS, 32'h15, "status_rx");
    check("irq_level", 32'h1, {31'h0, interrupt});
    rd_chk(`OFF_RX_PORT, 32'h3C, "rx_char");
    check("irq_gone", 32'h0, {31'h0, interrupt});
    serial_peer_inst.send(8'h81, 1'b1, 1'b0);
    rd_chk(`OFF_STATUS, 32'h95, "status_par");
    rd_chk(`OFF_STATUS, 32'h15, "par_cleared");
    rd_chk(`OFF_RX_PORT, 32'h81, "par_char");
    serial_peer_inst.send(8'h42, 1'b0, 1'b1);
    rd_chk(`OFF_STATUS, 32'h54, "status_frame");
    rd_chk(`OFF_STATUS, 32'h14, "frame_cleared");
    $display("test rx done");
  endtask : t_rx

  // Seventeen frames into a sixteen-deep queue, then clear it
  task automatic t_overrun;
    int i;
    for (i = 0; i < 17; i++)
      serial_peer_inst.send(8'h20 + i[7:0], 1'b0, 1'b0);
    rd_chk(`OFF_STATUS, 32'h37, "status_ovr");
    rd_chk(`OFF_RX_PORT, 32'h20, "first_char");
    rd_chk(`OFF_STATUS, 32'h15, "one_popped");
    wr(`OFF_CTRL, 32'h12);
    rd_chk(`OFF_STATUS, 32'h14, "rx_cleared");
    $display("test overrun done");
  endtask : t_overrun

  // Fill transmit queue with interrupts off, then clear it
  task automatic t_txfull;
    int i;
    wr(`OFF_CTRL, 32'h00);
    for (i = 0; i < 17; i++)
      wr(`OFF_TX_PORT, {24'h0, i[7:0]});
    rd_chk(`OFF_STATUS, 32'h08, "tx_full");
    wr(`OFF_CTRL, 32'h01);
    rd_chk(`OFF_STATUS, 32'h04, "tx_cleared");
    repeat (2 * 11 * bit_clks) @(posedge clk);
    $display("test txfull done");
  endtask : t_txfull

  initial
  begin
    errors = 0;
    n_checks = 0;
    irq_cnt = 0;
    rst = 1'b1;
    bus_addr = '0;
    bus_be = 4'hF;
    bus_wdata = '0;
    bus_rnw = 1'b1;
    bus_select = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_overrun();
    t_txfull();
    end_sim();
  end
endmodule : testbench
